// ===== rtl/tcr_pkg.sv
// Constants for the transmitter clock ratio and reset control block
// Operation
// - TMDS clock is data rate/10 below 3.4 Gb/s, data rate/40 above.
// - Data clock equals TMDS clock below threshold, four times it above.
// - Link clock is data clock/2 for dual pixel, /4 for quad pixel.
// - Pixel clock is data clock at 8, /1.25, /1.5, /2 at 10,12,16 bpc.
// - Video clock is pixel clock/2 for dual pixel, /4 for quad pixel.
// - Compressed audio fs for N/CTS is frame rate, quarter above 192 kHz.
// - Register, video stream and audio stream take independent clocks.
// - Three bus interfaces each have their own active-low reset input.
// - Native video mode drives a video reset output for the source.
// - Stream video is converted to timed video by a timing generator.
// - Native video passes straight to the core without conversion.
`default_nettype none
package tcr_pkg;
  localparam int FW = 24;
  localparam int RW = 13;
  localparam int AW = 20;
  localparam logic [RW-1:0] RATE_THR_MBPS = 13'hD48;
  localparam logic [FW-1:0] MHZ_TO_KHZ = 24'h0003E8;
  localparam logic [FW-1:0] TMDS_DIV_LO = 24'h00000A;
  localparam logic [FW-1:0] TMDS_DIV_HI = 24'h000028;
  localparam logic [FW-1:0] DATA_MUL_HI = 24'h000004;
  localparam logic [FW-1:0] PPC_DUAL = 24'h000002;
  localparam logic [FW-1:0] PPC_QUAD = 24'h000004;
  // Pixel ratios as numerator over denominator of the data clock
  localparam logic [FW-1:0] PIX10_NUM = 24'h000004;
  localparam logic [FW-1:0] PIX10_DEN = 24'h000005;
  localparam logic [FW-1:0] PIX12_NUM = 24'h000002;
  localparam logic [FW-1:0] PIX12_DEN = 24'h000003;
  localparam logic [FW-1:0] PIX16_DEN = 24'h000002;
  localparam logic [31:0] AUD_CLK_MULT = 32'h00000080;
  localparam logic [AW-1:0] HBR_FS_LIM_KHZ = 20'h000C0;
  localparam logic [AW-1:0] HBR_FS_DIV = 20'h00004;
  localparam int MCLK_MHZ = 50;
  localparam int HOLD_TIME_NS = 1000;
  localparam int HOLD_CYC_I = (HOLD_TIME_NS * MCLK_MHZ + 999) / 1000;
  localparam int CW = 8;
  localparam logic [CW-1:0] HOLD_CYC = CW'(HOLD_CYC_I);
  localparam int NSYNC = 5;
  localparam int SY_CPU = 0;
  localparam int SY_VSTR = 1;
  localparam int SY_ASTR = 2;
  localparam int SY_LLOCK = 3;
  localparam int SY_VLOCK = 4;
  typedef enum logic [1:0] {
    BPC_8  = 2'h0,
    BPC_10 = 2'h1,
    BPC_12 = 2'h2,
    BPC_16 = 2'h3
  } tcr_bpc_t;
  typedef enum logic [1:0] {
    VIF_STREAM = 2'h0,
    VIF_NATIVE = 2'h1,
    VIF_NATVEC = 2'h2
  } tcr_vif_t;
  typedef enum logic [1:0] {
    ST_HOLD  = 2'h0,
    ST_COUNT = 2'h1,
    ST_RUN   = 2'h3
  } tcr_state_t;
endpackage
`default_nettype wire

// ===== rtl/tcr_ctrl.sv
// Clock ratio calculator and reset sequencer for the transmitter
`default_nettype none
module tcr_ctrl (
  // Clock, reset, enable
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  // Configuration
  input  wire logic [tcr_pkg::RW-1:0]    line_rate_mbps,
  input  wire logic                      quad_ppc,
  input  wire logic [1:0]                bpc_sel,
  input  wire logic [1:0]                vif_sel,
  // Audio
  input  wire logic [tcr_pkg::AW-1:0]    aud_clk_khz,
  input  wire logic [tcr_pkg::AW-1:0]    aud_fs_khz,
  input  wire logic [tcr_pkg::AW-1:0]    aud_frame_khz,
  // Resets and locks from other domains
  input  wire logic                      cpu_rst_n,
  input  wire logic                      vstr_rst_n,
  input  wire logic                      astr_rst_n,
  input  wire logic                      link_lock,
  input  wire logic                      vid_lock,
  // Derived frequencies in kHz and the high-rate flag
  output logic [tcr_pkg::FW-1:0]         tmds_khz,
  output logic [tcr_pkg::FW-1:0]         data_khz,
  output logic [tcr_pkg::FW-1:0]         link_khz,
  output logic [tcr_pkg::FW-1:0]         pixel_khz,
  output logic [tcr_pkg::FW-1:0]         video_khz,
  output logic                           rate_high,
  // Audio status
  output logic                           aud_clk_ok,
  output logic [tcr_pkg::AW-1:0]         acr_fs_khz,
  // Domain resets and video path
  output logic                           cpu_dom_rst_n,
  output logic                           vstr_dom_rst_n,
  output logic                           astr_dom_rst_n,
  output logic                           link_rst,
  output logic                           video_rst,
  output logic                           conv_en,
  output logic                           native_pass
);

  localparam int FW = tcr_pkg::FW;
  localparam int AW = tcr_pkg::AW;
  localparam int CW = tcr_pkg::CW;
  localparam int NS = tcr_pkg::NSYNC;

  // Synchroniser stages
  logic [NS-1:0] sy_a_ff;
  logic [NS-1:0] sy_b_ff;
  logic [NS-1:0] sy_in;

  assign sy_in = {vid_lock, link_lock, astr_rst_n, vstr_rst_n, cpu_rst_n};

  // Two-flop synchroniser for each foreign level
  always_ff @(posedge mclk) begin
    if (srst) begin
      sy_a_ff <= '0;
      sy_b_ff <= '0;
    end else if (ce) begin
      sy_a_ff <= sy_in;
      sy_b_ff <= sy_a_ff;
    end
  end

  // Ratio state
  logic [FW-1:0] tmds_ff, data_ff, link_ff, pix_ff, vid_ff;
  logic [FW-1:0] nxt_tmds, nxt_data, nxt_link, nxt_pix, nxt_vid;
  logic          hi_ff, nxt_hi;
  logic          quad_ff, nxt_quad;
  logic [1:0]    bpc_ff, nxt_bpc;
  logic [FW-1:0] rate_k;
  logic [FW-1:0] ppc;

  always_comb begin
    rate_k   = FW'(line_rate_mbps) * tcr_pkg::MHZ_TO_KHZ;
    nxt_hi   = line_rate_mbps > tcr_pkg::RATE_THR_MBPS;
    nxt_quad = quad_ppc;
    nxt_bpc  = bpc_sel;
    ppc      = quad_ppc ? tcr_pkg::PPC_QUAD : tcr_pkg::PPC_DUAL;
    if (nxt_hi) begin
      nxt_tmds = rate_k / tcr_pkg::TMDS_DIV_HI;
      nxt_data = nxt_tmds * tcr_pkg::DATA_MUL_HI;
    end else begin
      nxt_tmds = rate_k / tcr_pkg::TMDS_DIV_LO;
      nxt_data = nxt_tmds;
    end
    nxt_link = nxt_data / ppc;
    case (bpc_sel)
      tcr_pkg::BPC_10: begin
        nxt_pix = (nxt_data * tcr_pkg::PIX10_NUM) / tcr_pkg::PIX10_DEN;
      end
      tcr_pkg::BPC_12: begin
        nxt_pix = (nxt_data * tcr_pkg::PIX12_NUM) / tcr_pkg::PIX12_DEN;
      end
      tcr_pkg::BPC_16: begin
        nxt_pix = nxt_data / tcr_pkg::PIX16_DEN;
      end
      default: begin
        nxt_pix = nxt_data;
      end
    endcase
    nxt_vid = nxt_pix / ppc;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tmds_ff <= '0;
      data_ff <= '0;
      link_ff <= '0;
      pix_ff  <= '0;
      vid_ff  <= '0;
      hi_ff   <= 1'b0;
      quad_ff <= 1'b0;
      bpc_ff  <= 2'h0;
    end else if (ce) begin
      tmds_ff <= nxt_tmds;
      data_ff <= nxt_data;
      link_ff <= nxt_link;
      pix_ff  <= nxt_pix;
      vid_ff  <= nxt_vid;
      hi_ff   <= nxt_hi;
      quad_ff <= nxt_quad;
      bpc_ff  <= nxt_bpc;
    end
  end

  assign tmds_khz  = tmds_ff;
  assign data_khz  = data_ff;
  assign link_khz  = link_ff;
  assign pixel_khz = pix_ff;
  assign video_khz = vid_ff;
  assign rate_high = hi_ff;

  // Audio clock check and regeneration sample rate
  logic          aok_ff, nxt_aok;
  logic [AW-1:0] acr_ff, nxt_acr;

  always_comb begin
    // No local audio clock recovery, so flag a too-slow source
    nxt_aok = 32'(aud_clk_khz) >=
              32'(aud_fs_khz) * tcr_pkg::AUD_CLK_MULT;
    if (aud_frame_khz > tcr_pkg::HBR_FS_LIM_KHZ) begin
      nxt_acr = aud_frame_khz / tcr_pkg::HBR_FS_DIV;
    end else begin
      nxt_acr = aud_frame_khz;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      aok_ff <= 1'b0;
      acr_ff <= '0;
    end else if (ce) begin
      aok_ff <= nxt_aok;
      acr_ff <= nxt_acr;
    end
  end

  assign aud_clk_ok = aok_ff;
  assign acr_fs_khz = acr_ff;

  // Reset sequencer
  tcr_pkg::tcr_state_t st_ff, nxt_st;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          cpu_ff, vstr_ff, astr_ff, lrst_ff, vrst_ff;
  logic          nxt_cpu, nxt_vstr, nxt_astr, nxt_lrst, nxt_vrst;
  logic          conv_ff, pass_ff, nxt_conv, nxt_pass;
  logic          locked;
  logic          native;
  logic          run;

  always_comb begin
    locked  = sy_b_ff[tcr_pkg::SY_LLOCK] & sy_b_ff[tcr_pkg::SY_VLOCK];
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      tcr_pkg::ST_HOLD: begin
        nxt_cnt = '0;
        if (locked) begin
          nxt_st = tcr_pkg::ST_COUNT;
        end
      end
      tcr_pkg::ST_COUNT: begin
        if (!locked) begin
          nxt_st = tcr_pkg::ST_HOLD;
        end else if (cnt_ff == tcr_pkg::HOLD_CYC - 8'h01) begin
          nxt_st = tcr_pkg::ST_RUN;
        end else begin
          nxt_cnt = cnt_ff + 8'h01;
        end
      end
      tcr_pkg::ST_RUN: begin
        if (!locked) begin
          nxt_st = tcr_pkg::ST_HOLD;
        end
      end
      default: begin
        nxt_st = tcr_pkg::ST_HOLD;
      end
    endcase
    run      = nxt_st == tcr_pkg::ST_RUN;
    native   = vif_sel != tcr_pkg::VIF_STREAM;
    nxt_cpu  = run & sy_b_ff[tcr_pkg::SY_CPU];
    nxt_astr = run & sy_b_ff[tcr_pkg::SY_ASTR];
    // Native mode has no video reset input
    nxt_vstr = run & (native | sy_b_ff[tcr_pkg::SY_VSTR]);
    nxt_lrst = !run;
    nxt_vrst = native & !run;
    nxt_conv = !native & nxt_vstr;
    nxt_pass = native & run;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff   <= tcr_pkg::ST_HOLD;
      cnt_ff  <= '0;
      cpu_ff  <= 1'b0;
      vstr_ff <= 1'b0;
      astr_ff <= 1'b0;
      lrst_ff <= 1'b1;
      vrst_ff <= 1'b0;
      conv_ff <= 1'b0;
      pass_ff <= 1'b0;
    end else if (ce) begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      cpu_ff  <= nxt_cpu;
      vstr_ff <= nxt_vstr;
      astr_ff <= nxt_astr;
      lrst_ff <= nxt_lrst;
      vrst_ff <= nxt_vrst;
      conv_ff <= nxt_conv;
      pass_ff <= nxt_pass;
    end
  end

  assign cpu_dom_rst_n  = cpu_ff;
  assign vstr_dom_rst_n = vstr_ff;
  assign astr_dom_rst_n = astr_ff;
  assign link_rst       = lrst_ff;
  assign video_rst      = vrst_ff;
  assign conv_en        = conv_ff;
  assign native_pass    = pass_ff;

  // Checks
  a_tmds_data_ratio: assert property (@(posedge mclk) disable iff (srst)
    data_ff == (hi_ff ? tmds_ff * tcr_pkg::DATA_MUL_HI : tmds_ff))
    else $error("data clock not tied to tmds clock");

  a_tmds_rate_div: assert property (@(posedge mclk) disable iff (srst)
    ce && !srst ##1 $stable(line_rate_mbps) && ce |=>
    tmds_ff == (FW'($past(line_rate_mbps)) * tcr_pkg::MHZ_TO_KHZ)
      / (hi_ff ? tcr_pkg::TMDS_DIV_HI : tcr_pkg::TMDS_DIV_LO))
    else $error("tmds clock not rate divided");

  a_link_ppc_div: assert property (@(posedge mclk) disable iff (srst)
    link_ff == data_ff / (quad_ff ? tcr_pkg::PPC_QUAD : tcr_pkg::PPC_DUAL))
    else $error("link clock ratio wrong");

  a_pixel_bpc16: assert property (@(posedge mclk) disable iff (srst)
    bpc_ff == tcr_pkg::BPC_16 |-> pix_ff == data_ff / tcr_pkg::PIX16_DEN)
    else $error("pixel clock wrong at 16 bpc");

  a_video_ppc_div: assert property (@(posedge mclk) disable iff (srst)
    vid_ff == pix_ff / (quad_ff ? tcr_pkg::PPC_QUAD : tcr_pkg::PPC_DUAL))
    else $error("video clock ratio wrong");

  a_acr_hbr_fs: assert property (@(posedge mclk) disable iff (srst)
    ce && $past(ce) && aud_frame_khz > tcr_pkg::HBR_FS_LIM_KHZ ##1
    $past(ce) |-> acr_ff == $past(aud_frame_khz) / tcr_pkg::HBR_FS_DIV)
    else $error("compressed audio fs not quartered");

  a_hold_count: assert property (@(posedge mclk) disable iff (srst)
    $rose(st_ff == tcr_pkg::ST_RUN) |->
    $past(st_ff) == tcr_pkg::ST_COUNT &&
    $past(cnt_ff) == tcr_pkg::HOLD_CYC - 8'h01)
    else $error("run entered without full hold");

  a_video_rst_out: assert property (@(posedge mclk) disable iff (srst)
    ce && vif_sel != tcr_pkg::VIF_STREAM && !locked
    |=> video_rst && !native_pass)
    else $error("native video reset not driven");

  a_path_select: assert property (@(posedge mclk) disable iff (srst)
    !(conv_en && native_pass) && (!native_pass || !link_rst))
    else $error("stream and native path both active");

  a_acr_fs_pass: assert property (@(posedge mclk) disable iff (srst)
    ce && aud_frame_khz <= tcr_pkg::HBR_FS_LIM_KHZ |=>
    acr_ff == $past(aud_frame_khz))
    else $error("compressed audio fs not passed through");

  a_dom_rst_run: assert property (@(posedge mclk) disable iff (srst)
    (cpu_dom_rst_n || vstr_dom_rst_n || astr_dom_rst_n) |-> !link_rst)
    else $error("domain reset released outside run");

  a_conv_gate: assert property (@(posedge mclk) disable iff (srst)
    conv_en |-> vstr_dom_rst_n && !link_rst)
    else $error("stream conversion enabled in reset");

endmodule // tcr_ctrl
`default_nettype wire

// ===== bench/tcr_phy_model.sv
// Transceiver controller model that supplies the clock lock indications
`default_nettype none
module tcr_phy_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Clock request and settling time in cycles
  input  wire logic       clk_req,
  input  wire logic [7:0] dly,
  // Lock levels
  output logic            link_lock,
  output logic            vid_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!clk_req) begin
      nxt_cnt = 8'h00;
    end else if (cnt_ff != 8'hFF) begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  // Link clock settles first, video clock later
  assign link_lock = clk_req && (cnt_ff >= (dly >> 1));
  assign vid_lock  = clk_req && (cnt_ff >= dly);
endmodule // tcr_phy_model
`default_nettype wire

// ===== bench/tb_tx_clock_reset_domains.sv
// Testbench for the clock ratio and reset sequencing block
`default_nettype none
module tb_tx_clock_reset_domains;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, srst = 1'b1, ce = 1'b1, quad_ppc = 1'b0, clk_req = 1'b0;
  logic [12:0] line_rate_mbps = 13'h0000;
  logic [1:0]  bpc_sel = 2'h0, vif_sel = 2'h0;
  logic [19:0] aud_clk_khz = 20'h00000, aud_fs_khz = 20'h00000;
  logic [19:0] aud_frame_khz = 20'h00000;
  logic cpu_rst_n = 1'b1, vstr_rst_n = 1'b1, astr_rst_n = 1'b1;
  logic [7:0] dly = 8'h28;
  logic link_lock, vid_lock, rate_high, aud_clk_ok;
  logic [23:0] tmds_khz, data_khz, link_khz, pixel_khz, video_khz;
  logic [19:0] acr_fs_khz;
  logic cpu_dom_rst_n, vstr_dom_rst_n, astr_dom_rst_n;
  logic link_rst, video_rst, conv_en, native_pass;
  int fail_count = 0, checks = 0;
  tcr_phy_model u_phy (.mclk(mclk), .srst(srst), .clk_req(clk_req),
    .dly(dly), .link_lock(link_lock), .vid_lock(vid_lock));
  tcr_ctrl u_dut (.mclk(mclk), .srst(srst), .ce(ce),
    .line_rate_mbps(line_rate_mbps), .quad_ppc(quad_ppc), .bpc_sel(bpc_sel),
    .vif_sel(vif_sel), .aud_clk_khz(aud_clk_khz), .aud_fs_khz(aud_fs_khz),
    .aud_frame_khz(aud_frame_khz), .cpu_rst_n(cpu_rst_n),
    .vstr_rst_n(vstr_rst_n), .astr_rst_n(astr_rst_n), .link_lock(link_lock),
    .vid_lock(vid_lock), .tmds_khz(tmds_khz), .data_khz(data_khz),
    .link_khz(link_khz), .pixel_khz(pixel_khz), .video_khz(video_khz),
    .rate_high(rate_high), .aud_clk_ok(aud_clk_ok), .acr_fs_khz(acr_fs_khz),
    .cpu_dom_rst_n(cpu_dom_rst_n), .vstr_dom_rst_n(vstr_dom_rst_n),
    .astr_dom_rst_n(astr_dom_rst_n), .link_rst(link_rst),
    .video_rst(video_rst), .conv_en(conv_en), .native_pass(native_pass));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      $display("unexpected %s expected %0d seen %0d", name, exp, seen);
      fail_count++;
    end
  endtask
  task automatic close_out;
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic reset_values;
    check("tmds", tmds_khz, 0);
    check("link_rst", link_rst, 1);
    check("cpu_dom", cpu_dom_rst_n, 0);
    check("video_rst", video_rst, 0);
  endtask
  task automatic ratios;
    int rates[3] = '{2970, 3400, 5940};
    int t, d, l, p, v, hi;
    for (int i = 0; i < 3; i++) begin
      for (int b = 0; b < 4; b++) begin
        for (int q = 0; q < 2; q++) begin
          line_rate_mbps = rates[i][12:0];
          bpc_sel = b[1:0];
          quad_ppc = q[0];
          cyc(2);
          hi = (rates[i] > 3400) ? 1 : 0;
          t = rates[i] * 1000 / (hi ? 40 : 10);
          d = hi ? t * 4 : t;
          l = d / (q ? 4 : 2);
          p = (b == 0) ? d : (b == 1) ? d * 4 / 5 :
              (b == 2) ? d * 2 / 3 : d / 2;
          v = p / (q ? 4 : 2);
          check("rate_high", rate_high, hi);
          check("tmds", tmds_khz, t);
          check("data", data_khz, d);
          check("link", link_khz, l);
          check("pixel", pixel_khz, p);
          check("video", video_khz, v);
        end
      end
    end
    // Clock enable low must freeze the last result
    ce = 1'b0;
    line_rate_mbps = 13'h0B9A;
    cyc(2);
    check("tmds_frozen", tmds_khz, 148500);
    ce = 1'b1;
    cyc(2);
    check("tmds", tmds_khz, 297000);
  endtask
  task automatic audio;
    int tb[3][5] = '{'{6144, 48, 768, 1, 192}, '{6143, 48, 192, 0, 192},
                     '{24576, 192, 193, 1, 48}};
    for (int i = 0; i < 3; i++) begin
      aud_clk_khz = tb[i][0][19:0];
      aud_fs_khz = tb[i][1][19:0];
      aud_frame_khz = tb[i][2][19:0];
      cyc(2);
      check("aud_clk_ok", aud_clk_ok, tb[i][3]);
      check("acr_fs", acr_fs_khz, tb[i][4]);
    end
  endtask
  task automatic sequencing;
    int n;
    vif_sel = 2'h0;
    clk_req = 1'b1;
    n = 0;
    while (vid_lock !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    check("link_rst_held", link_rst, 1);
    n = 0;
    while (link_rst !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
    // Two sync edges, hold entry edge, then the full hold count
    check("release_delay", n, tcr_pkg::HOLD_CYC_I + 3);
    check("cpu_dom", cpu_dom_rst_n, 1);
    check("astr_dom", astr_dom_rst_n, 1);
    check("conv_en", conv_en, 1);
    check("native_pass", native_pass, 0);
    vstr_rst_n = 1'b0;
    cyc(4);
    check("vstr_dom", vstr_dom_rst_n, 0);
    check("conv_en", conv_en, 0);
    check("cpu_dom", cpu_dom_rst_n, 1);
    for (int m = 1; m < 3; m++) begin
      vif_sel = m[1:0];
      cyc(4);
      check("native_pass", native_pass, 1);
      check("vstr_dom", vstr_dom_rst_n, 1);
      check("video_rst", video_rst, 0);
    end
    vstr_rst_n = 1'b1;
    clk_req = 1'b0;
    cyc(6);
    check("video_rst", video_rst, 1);
    check("link_rst", link_rst, 1);
    check("cpu_dom", cpu_dom_rst_n, 0);
    check("native_pass", native_pass, 0);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    close_out();
  end
  initial begin
    cyc(20);
    srst = 1'b0;
    cyc(1);
    reset_values();
    ratios();
    audio();
    sequencing();
    close_out();
  end
endmodule // tb_tx_clock_reset_domains
`default_nettype wire
